/* File: hw/mmt_timer.sv */
// How it works
// - software writes a 16-bit reload value as low and high byte.
// - once watchdog mode runs, reload byte writes are ignored.
// - 16-bit snapshot bytes are read/write; plain scratch outside capture.
// - three mode bits pick five modes; frozen once watchdog runs.
// - watchdog can be started and cleared but never stopped.
// - missing watchdog clear lets counter underflow into an internal reset.
// - counter counts down outside capture; reload defaults to ffff after external reset.
// - watchdog loads reload value on start and every clear.
// - watchdog reset keeps mode and reload, sets cause flag, restarts ffff.
// - interrupt mode underflow raises request and source flag bit 1.
// - interrupt mode reloads at underflow; reload rewrite and clear allowed.
// - polling mode reaching zero gives no reset, no interrupt; reloads.
// - capture 0: first falling edge restarts, later edges latch then restart.
// - capture start value is complement of reload bytes.
// - capture ends on mode change or reset; last snapshot stays on a mode change, reset clears it to 00.
// - capture 1 requests interrupt per capture or overflow; zero flag tells.
// - any access to the mode/status register clears the zero flag.
// - clear bit set before start bit reloads; clear bit self-clears.
`include "mmt_cfg.svh"

module mmt_timer #(
  parameter int ADDR_WIDTH = 12
) (
  input  wire logic                  clk,
  input  wire logic                  rst_b,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [ADDR_WIDTH-1:0] paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic                  timestampEdgeInputPin,
  input  wire logic                  timerPwmInterruptEnable,
  input  wire logic                  globalInterruptEnable,
  output logic                       interruptRequest,
  output logic                       sourceFlagSet,
  output logic                       internalResetOut
);

  // ****************************************************************
  // elaboration check
  // ****************************************************************
  // the highest register sits at byte address 0x25c
  if (ADDR_WIDTH < 10 || ADDR_WIDTH > 32) begin : g_bad_width
    $error("mmt_timer: ADDR_WIDTH must be 10 to 32");
  end

  // ****************************************************************
  // register state
  // ****************************************************************
  logic [7:0]  reloadLo;
  logic [7:0]  reloadHi;
  logic [7:0]  snapLo;
  logic [7:0]  snapHi;
  logic [2:0]  modeBits;
  logic [1:0]  prescale;
  logic        resetCause;
  logic        zeroFlag;
  logic        startBit;
  logic        clearPending;
  logic        running;
  logic        captureArmed;
  logic [15:0] counter;
  logic [5:0]  preCount;
  logic        syncA;
  logic        syncB;
  logic        syncPrev;

  // ****************************************************************
  // decode helpers
  // ****************************************************************
  // address decode is needed for both read mux and write strobes
  function automatic logic hit(input logic [ADDR_WIDTH-1:0] a,
                               input logic [7:0] idx);
    hit = (a == ADDR_WIDTH'({idx, 2'b00}));
  endfunction

  // capture modes share the m0/m2 pattern
  function automatic logic isCapture(input logic [2:0] m);
    isCapture = (m == mmt_pkg::MMT_CAPTURE0) ||
                (m == mmt_pkg::MMT_CAPTURE1);
  endfunction

  // ****************************************************************
  // bus decode
  // ****************************************************************
  wire accessDone = psel & penable & pready;
  wire wrDone     = accessDone & pwrite;
  wire selRelLo   = hit(paddr, `MMT_IDX_RELOAD_LO);
  wire selRelHi   = hit(paddr, `MMT_IDX_RELOAD_HI);
  wire selSnapLo  = hit(paddr, `MMT_IDX_SNAP_LO);
  wire selSnapHi  = hit(paddr, `MMT_IDX_SNAP_HI);
  wire selMode    = hit(paddr, `MMT_IDX_MODE);
  wire selClear   = hit(paddr, `MMT_IDX_CLEAR);
  wire selAny     = selRelLo | selRelHi | selSnapLo | selSnapHi |
                    selMode | selClear;
  wire [7:0] wByte = pwdata[7:0];

  // ****************************************************************
  // mode and control decode
  // ****************************************************************
  wire isWatchdog = (modeBits == mmt_pkg::MMT_WATCHDOG);
  wire isIntMode  = (modeBits == mmt_pkg::MMT_INTERRUPT);
  wire isCap      = isCapture(modeBits);
  wire isCap1     = (modeBits == mmt_pkg::MMT_CAPTURE1);
  wire wdLocked   = isWatchdog & running;
  wire wrMode     = wrDone & selMode;
  wire wrStart    = wrMode & wByte[`MMT_BIT_START];
  // a start write on a stopped timer starts it, on a running one with the clear bit set clears it
  wire doStart    = wrStart & ~running;
  wire doClear    = wrStart & running & clearPending;
  wire doLoad     = doStart | doClear;
  wire [2:0] newMode = {wByte[`MMT_BIT_M2], wByte[`MMT_BIT_M1],
                        wByte[`MMT_BIT_M0]};
  wire [2:0] effMode = wdLocked ? modeBits : newMode;
  wire modeChange = wrMode & (effMode != modeBits);
  wire [15:0] reloadVal = {reloadHi, reloadLo};
  wire [15:0] capStart  = ~reloadVal;

  // ****************************************************************
  // prescaler
  // ****************************************************************
  // prescale_high_bit set wins over prescale_low_bit, giving the /12 choice
  wire [5:0] preDiv = prescale[1] ? `MMT_DIV_12 :
                      (prescale[0] ? `MMT_DIV_24 : `MMT_DIV_48);
  // a prescale change mid-period may leave preCount above the new top
  wire tick = running & (preCount >= preDiv - 6'd1);

  // ****************************************************************
  // capture pin edge detect
  // ****************************************************************
  // the edge looks only at the second stage and the stage after it
  wire fallEdge = syncPrev & ~syncB;
  wire capEvent = running & isCap & fallEdge & captureArmed;
  wire capFirst = running & isCap & fallEdge & ~captureArmed;

  // ****************************************************************
  // counter events
  // ****************************************************************
  wire downZero = tick & ~isCap & (counter == 16'h0000);
  wire upWrap   = tick & isCap & (counter == `MMT_CNT_TOP);
  wire wdFire   = downZero & isWatchdog;
  wire intFire  = (downZero & isIntMode) |
                  (isCap1 & (capEvent | upWrap));
  wire zeroSet  = downZero | (isCap1 & upWrap);

  // ****************************************************************
  // next counter value
  // ****************************************************************
  logic [15:0] next_counter;
  always_comb begin
    next_counter = counter;
    if (doLoad) begin
      // the start write names the mode the load must serve
      next_counter = isCapture(effMode) ? capStart :
                     reloadVal;
    end else if (wdFire) begin
      next_counter = `MMT_CNT_TOP;
    end else if (capFirst || capEvent) begin
      next_counter = capStart;
    end else if (downZero) begin
      next_counter = reloadVal;
    end else if (tick && isCap) begin
      next_counter = counter + 16'h0001;
    end else if (tick) begin
      next_counter = counter - 16'h0001;
    end
  end

  // ****************************************************************
  // read mux
  // ****************************************************************
  wire [7:0] modeRead = {zeroFlag, prescale[1], prescale[0],
                         modeBits[2], modeBits[1], modeBits[0],
                         resetCause, startBit};
  wire [7:0] clearRead = {1'b1, clearPending, 6'h3f};
  wire [7:0] rdByte =
    selRelLo  ? reloadLo :
    selRelHi  ? reloadHi :
    selSnapLo ? snapLo :
    selSnapHi ? snapHi :
    selMode   ? modeRead :
    selClear  ? clearRead : 8'h00;

  // ****************************************************************
  // apb slave
  // ****************************************************************
  // one wait state so that read data and error come from flops
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & penable & ~pready;
      prdata  <= {24'h00_0000, rdByte};
      pslverr <= psel & penable & ~pready & ~selAny;
    end
  end

  // ****************************************************************
  // reload bytes
  // ****************************************************************
  // software writes vanish once the watchdog has been started
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      reloadLo <= `MMT_RST_RELOAD;
      reloadHi <= `MMT_RST_RELOAD;
    end else begin
      if (wrDone && selRelLo && !wdLocked) begin
        reloadLo <= wByte;
      end
      if (wrDone && selRelHi && !wdLocked) begin
        reloadHi <= wByte;
      end
    end
  end

  // ****************************************************************
  // snapshot bytes
  // ****************************************************************
  // a capture in the same cycle as a software write wins
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      snapLo <= `MMT_RST_SNAP;
      snapHi <= `MMT_RST_SNAP;
    end else if (capEvent) begin
      snapLo <= counter[7:0];
      snapHi <= counter[15:8];
    end else begin
      if (wrDone && selSnapLo) begin
        snapLo <= wByte;
      end
      if (wrDone && selSnapHi) begin
        snapHi <= wByte;
      end
    end
  end

  // ****************************************************************
  // mode/status register
  // ****************************************************************
  // the watchdog reset leaves mode and prescale alone
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      modeBits <= 3'(`MMT_RST_MODE >> `MMT_BIT_M0);
      prescale <= 2'b00;
      startBit <= 1'b1;
    end else if (wrMode && !wdLocked) begin
      modeBits <= newMode;
      prescale <= {wByte[`MMT_BIT_PRESCALE_HIGH_BIT], wByte[`MMT_BIT_PRESCALE_LOW_BIT]};
      startBit <= wByte[`MMT_BIT_START];
    end
  end

  // reset cause survives the watchdog reset it records
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      resetCause <= 1'b0;
    end else if (wdFire) begin
      resetCause <= 1'b1;
    end
  end

  // hardware set wins over the clear by access
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      zeroFlag <= 1'b0;
    end else if (zeroSet) begin
      zeroFlag <= 1'b1;
    end else if (accessDone && selMode) begin
      zeroFlag <= 1'b0;
    end
  end

  // ****************************************************************
  // clear request bit
  // ****************************************************************
  // consumed by the next start write
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      clearPending <= 1'(`MMT_RST_CLEAR >> `MMT_BIT_CLEAR);
    end else if (wrDone && selClear) begin
      clearPending <= wByte[`MMT_BIT_CLEAR];
    end else if (wrStart) begin
      clearPending <= 1'b0;
    end
  end

  // ****************************************************************
  // run state
  // ****************************************************************
  // there is no stop path: only the external reset halts the counter
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      running <= 1'b0;
    end else if (doStart) begin
      running <= 1'b1;
    end
  end

  // first falling edge arms the capture logic and restarts the count without latching
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      captureArmed <= 1'b0;
    end else if (modeChange || doStart) begin
      captureArmed <= 1'b0;
    end else if (capFirst) begin
      captureArmed <= 1'b1;
    end
  end

  // ****************************************************************
  // counter and prescaler
  // ****************************************************************
  // a load restarts the prescaler so the first period is whole
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      counter  <= 16'h0000;
      preCount <= 6'd0;
    end else begin
      counter <= next_counter;
      if (doLoad || tick || !running) begin
        preCount <= 6'd0;
      end else begin
        preCount <= preCount + 6'd1;
      end
    end
  end

  // ****************************************************************
  // capture pin synchroniser
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      syncA    <= 1'b1;
      syncB    <= 1'b1;
      syncPrev <= 1'b1;
    end else begin
      syncA    <= timestampEdgeInputPin;
      syncB    <= syncA;
      syncPrev <= syncB;
    end
  end

  // ****************************************************************
  // event outputs
  // ****************************************************************
  // polling mode never drives these, so zero there is silent
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      interruptRequest <= 1'b0;
      sourceFlagSet    <= 1'b0;
      internalResetOut <= 1'b0;
    end else begin
      interruptRequest <= intFire & timerPwmInterruptEnable &
                          globalInterruptEnable;
      sourceFlagSet    <= intFire;
      internalResetOut <= wdFire;
    end
  end

endmodule // mmt_timer

/* File: include/mmt_cfg.svh */
`ifndef MMT_CFG_SVH
`define MMT_CFG_SVH

// register indices; byte address is four times the index
`define MMT_IDX_RELOAD_LO   8'h8e
`define MMT_IDX_RELOAD_HI   8'h8f
`define MMT_IDX_SNAP_LO     8'h91
`define MMT_IDX_SNAP_HI     8'h92
`define MMT_IDX_MODE        8'h96
`define MMT_IDX_CLEAR       8'h97

// mode/status register fields
`define MMT_BIT_START       0
`define MMT_BIT_CAUSE       1
`define MMT_BIT_M0          2
`define MMT_BIT_M1          3
`define MMT_BIT_M2          4
`define MMT_BIT_PRESCALE_LOW_BIT        5
`define MMT_BIT_PRESCALE_HIGH_BIT        6
`define MMT_BIT_ZERO        7
// clear register field
`define MMT_BIT_CLEAR       6

// reset values
`define MMT_RST_RELOAD      8'hff
`define MMT_RST_SNAP        8'h00
`define MMT_RST_MODE        8'h01
`define MMT_RST_CLEAR       8'hff
`define MMT_CNT_TOP         16'hffff

// prescaler divide ratios of the oscillator clock
`define MMT_DIV_48          6'd48
`define MMT_DIV_24          6'd24
`define MMT_DIV_12          6'd12

`endif

/* File: include/mmt_pkg.sv */
package mmt_pkg;

  // mode bits {m2, m1, m0}
  typedef enum logic [2:0] {
    MMT_WATCHDOG = 3'b000,
    MMT_INTERRUPT = 3'b001,
    MMT_POLLING = 3'b011,
    MMT_CAPTURE1 = 3'b101,
    MMT_CAPTURE0 = 3'b111
  } mmt_mode_type;

endpackage

/* File: test/mmt_pin_model.sv */
// ****************
// capture pin source
// ****************
module mmt_pin_model (
  input wire logic clk,
  input wire logic fall,
  output logic     pin
);
  timeunit 1ns;
  timeprecision 1ps;
  int lowLeft = 0;
  // pin rests high; held low long enough to clear the synchroniser
  always_ff @(posedge clk) begin
    if (fall) lowLeft <= 6;
    else if (lowLeft > 0) lowLeft <= lowLeft - 1;
  end
  assign pin = (lowLeft == 0);
endmodule // mmt_pin_model

/* File: test/mmt_timer_assertions.sv */
// ****************
// timer port checks
// ****************
module mmt_timer_assertions #(
  parameter int ADDR_WIDTH = 12
) (
  input wire logic                  clk,
  input wire logic                  rst_b,
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [ADDR_WIDTH-1:0] paddr,
  input wire logic [31:0]           pwdata,
  input wire logic [31:0]           prdata,
  input wire logic                  pready,
  input wire logic                  pslverr,
  input wire logic                  timestampEdgeInputPin,
  input wire logic                  timerPwmInterruptEnable,
  input wire logic                  globalInterruptEnable,
  input wire logic                  interruptRequest,
  input wire logic                  sourceFlagSet,
  input wire logic                  internalResetOut
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // one wait state, then a single-cycle answer
  a_ready_wait: assert property (
    $rose(penable) && psel |-> !pready ##1 pready)
    else $error("pready not in second access cycle");
  a_err_quiet: assert property (
    pslverr |-> pready && prdata == 32'h0)
    else $error("error answer carries data");
  a_upper_zero: assert property (
    pready |-> prdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  // requests must be gated by both enables of the previous cycle
  a_irq_gated: assert property (
    interruptRequest |->
    $past(timerPwmInterruptEnable) && $past(globalInterruptEnable))
    else $error("request without enables");
  a_flag_irq: assert property (
    sourceFlagSet && $past(timerPwmInterruptEnable) &&
    $past(globalInterruptEnable) |-> interruptRequest)
    else $error("enabled underflow gave no request");
  a_irq_pulse: assert property (
    interruptRequest |=> !interruptRequest)
    else $error("request longer than one cycle");
  // the watchdog reset never doubles as an interrupt
  a_wdog_pulse: assert property (
    internalResetOut |-> !interruptRequest ##1 !internalResetOut)
    else $error("bad internal reset pulse");
  a_reset_quiet: assert property (
    disable iff (1'b0) !rst_b |=>
    !pready && !internalResetOut && !interruptRequest)
    else $error("outputs active after reset");
endmodule // mmt_timer_assertions

bind mmt_timer mmt_timer_assertions #(.ADDR_WIDTH(ADDR_WIDTH)) u_chk (
  .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr),
  .timestampEdgeInputPin(timestampEdgeInputPin),
  .timerPwmInterruptEnable(timerPwmInterruptEnable),
  .globalInterruptEnable(globalInterruptEnable),
  .interruptRequest(interruptRequest), .sourceFlagSet(sourceFlagSet),
  .internalResetOut(internalResetOut));

/* File: test/test_mmt_timer.sv */
`include "mmt_cfg.svh"
// ****************
// timer bench
// ****************
module test_mmt_timer;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst_b, psel, penable, pwrite, fall, enGlb, enPw;
  logic        lastErr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, pin, irq, src, wdr;
  logic [7:0]  v, saved;
  int num_errors = 0, checked = 0, cyc = 0, nIrq = 0, nRst = 0;
  int lastSrc = 0, srcGap = 0, n0, r0, t0;
  logic [7:0]  modes [3] = '{8'h05, 8'h25, 8'h45};
  int          divs [3] = '{48, 24, 12};

  mmt_timer dut (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .timestampEdgeInputPin(pin),
    .timerPwmInterruptEnable(enPw), .globalInterruptEnable(enGlb),
    .interruptRequest(irq), .sourceFlagSet(src), .internalResetOut(wdr));
  mmt_pin_model far (.clk(clk), .fall(fall), .pin(pin));

  initial begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end

  // event counters; the cycle ceiling cuts a hang short
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (irq === 1'b1) nIrq <= nIrq + 1;
    if (wdr === 1'b1) nRst <= nRst + 1;
    if (src === 1'b1) begin
      srcGap <= cyc - lastSrc;
      lastSrc <= cyc;
    end
    if (cyc == 20000) begin
      num_errors++;
      final_report();
    end
  end

  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic check_bit(input logic got, input logic exp);
    check8({7'h0, got}, {7'h0, exp});
  endtask

  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] idx,
                     input logic [7:0] wd);
    psel <= 1;
    pwrite <= w;
    penable <= 0;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= {24'h0, wd};
    @(posedge clk);
    penable <= 1;
    // only the bench's cycle ceiling ends a wait that never answers
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    v = prdata[7:0];
    lastErr = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
  endtask

  task automatic rd(input logic [7:0] idx, input logic [7:0] m,
                    input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    check8(v & m, exp);
  endtask

  // captured counts may shift by a tick with prescaler phase
  task automatic rd_range(input logic [7:0] lo, input logic [7:0] hi);
    apb(1'b0, `MMT_IDX_SNAP_LO, 8'h00);
    check_bit(v >= lo && v <= hi, 1'b1);
  endtask

  task automatic reset_dut();
    rst_b <= 0;
    repeat (6) @(posedge clk);
    rst_b <= 1;
    @(posedge clk);
  endtask

  task automatic pin_fall(input int gap);
    fall <= 1;
    @(posedge clk);
    fall <= 0;
    repeat (gap) @(posedge clk);
  endtask

  task automatic final_report();
    $display("mismatches %0d comparisons %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    rst_b = 0; psel = 0; penable = 0; pwrite = 0;
    paddr = 0; pwdata = 0; fall = 0; enGlb = 1;
    enPw = 1;
    @(posedge clk);
    reset_dut();
    // defaults, unmapped place, scratch bytes
    rd(`MMT_IDX_RELOAD_LO, 8'hff, 8'hff);
    rd(`MMT_IDX_RELOAD_HI, 8'hff, 8'hff);
    rd(`MMT_IDX_SNAP_HI, 8'hff, 8'h00);
    rd(`MMT_IDX_MODE, 8'hff, 8'h01);
    rd(`MMT_IDX_CLEAR, 8'hff, 8'hff);
    rd(8'h90, 8'hff, 8'h00);
    check_bit(lastErr, 1'b1);
    wr(`MMT_IDX_SNAP_LO, 8'ha5);
    rd(`MMT_IDX_SNAP_LO, 8'hff, 8'ha5);
    $display("registers done");
    // interrupt mode at every prescale, each enable off once
    wr(`MMT_IDX_RELOAD_LO, 8'h03);
    wr(`MMT_IDX_RELOAD_HI, 8'h00);
    for (int i = 0; i < 3; i++) begin
      enGlb <= (i != 0);
      enPw <= (i != 1);
      n0 = nIrq;
      wr(`MMT_IDX_MODE, modes[i]);
      repeat (divs[i] * 12 + 20) @(posedge clk);
      check8(8'(srcGap), 8'(divs[i] * 4));
      check_bit(nIrq > n0, i == 2);
    end
    wr(`MMT_IDX_RELOAD_LO, 8'h07);
    repeat (250) @(posedge clk);
    check8(8'(srcGap), 8'd96);
    $display("interrupt mode done");
    // polling: zero is only flagged
    wr(`MMT_IDX_RELOAD_LO, 8'hff);
    wr(`MMT_IDX_MODE, 8'h4d);
    // let a pulse from the last interrupt-mode cycle settle first
    repeat (2) @(posedge clk);
    t0 = lastSrc;
    r0 = nRst;
    repeat (3200) @(posedge clk);
    check8(8'(lastSrc - t0), 8'h00);
    check8(8'(nRst - r0), 8'h00);
    rd(`MMT_IDX_MODE, 8'hff, 8'hcd);
    rd(`MMT_IDX_MODE, 8'hff, 8'h4d);
    $display("polling done");
    // capture mode 1, start value, leaving capture
    reset_dut();
    wr(`MMT_IDX_MODE, 8'h55);
    rd(`MMT_IDX_MODE, 8'h7f, 8'h55);
    n0 = nIrq;
    pin_fall(120);
    pin_fall(10);
    rd_range(8'd9, 8'd11);
    check8(8'(nIrq - n0), 8'h01);
    rd(`MMT_IDX_MODE, 8'hff, 8'h55);
    wr(`MMT_IDX_RELOAD_LO, 8'hf0);
    pin_fall(120);
    pin_fall(10);
    rd_range(8'd24, 8'd26);
    // capture mode 0: same measurement, no interrupt
    wr(`MMT_IDX_MODE, 8'h5d);
    n0 = nIrq;
    pin_fall(120);
    pin_fall(10);
    rd_range(8'd24, 8'd26);
    check8(8'(nIrq - n0), 8'h00);
    saved = v;
    wr(`MMT_IDX_MODE, 8'h4d);
    pin_fall(20);
    rd(`MMT_IDX_SNAP_LO, 8'hff, saved);
    $display("capture done");
    // watchdog: locked settings, clears, then a missed clear
    reset_dut();
    r0 = nRst;
    wr(`MMT_IDX_RELOAD_LO, 8'h03);
    wr(`MMT_IDX_RELOAD_HI, 8'h00);
    wr(`MMT_IDX_MODE, 8'h41);
    wr(`MMT_IDX_RELOAD_LO, 8'h77);
    rd(`MMT_IDX_RELOAD_LO, 8'hff, 8'h03);
    wr(`MMT_IDX_MODE, 8'h0d);
    rd(`MMT_IDX_MODE, 8'h7f, 8'h41);
    for (int i = 0; i < 6; i++) begin
      wr(`MMT_IDX_CLEAR, 8'h40);
      wr(`MMT_IDX_MODE, 8'h41);
      repeat (20) @(posedge clk);
    end
    rd(`MMT_IDX_CLEAR, 8'hff, 8'hbf);
    check8(8'(nRst - r0), 8'h00);
    repeat (100) @(posedge clk);
    check8(8'(nRst - r0), 8'h01);
    rd(`MMT_IDX_MODE, 8'h7f, 8'h43);
    rd(`MMT_IDX_RELOAD_LO, 8'hff, 8'h03);
    reset_dut();
    rd(`MMT_IDX_MODE, 8'hff, 8'h01);
    rd(`MMT_IDX_RELOAD_LO, 8'hff, 8'hff);
    $display("watchdog done");
    final_report();
  end
endmodule // test_mmt_timer
